// file: rtl/soft_start_sequencer.v
/*
 Turn-on sequencer of a buck output: four command registers, turn-on
 delay, reference ramp, start-up timeout watch and fault response.
 Assumes a command port that presents one decoded read or write per
 pulse on the system clock, and an output sense value in ADC counts.
*/
// Behaviour
// [R1] Wait programmed turn-on delay after start
// [R2] Delay register: exponent 15:11, mantissa 10:0
// [R3] Always at least 100 us initialization delay
// [R4] Out-of-range delay or rise write flags host
// [R5] Turn-on delay 0 to 127.5 ms, 0.5 ms
// [R6] Reload nearest supported delay after restore
// [R7] Rise register sets reference slew rate
// [R8] Ramp duration independent of target voltage
// [R9] Rise 0 to 31.75 ms, minimum 0.5 ms
// [R10] Slew rate may be coarsely quantized
// [R11] Timeout from delay end to 85% target
// [R12] Undervoltage armed only when rise ends
// [R13] Timeout limit 0 to 127 ms, 0.5 ms
// [R14] Zero timeout limit disables checking
// [R15] Timeout limit writes rejected as invalid
// [R16] Timeout fault sets three status bits, alerts
// [R17] Response byte: action, restart count, wait
// [R18] Action: ignore, delayed, immediate, else invalid
// [R19] Restart count: latch, 1 to 6, forever
// [R20] Wait code sets shutdown delay and restart_wait_period
// [R21] Times are mantissa times two to exponent
`timescale 1ns/100ps
`include "soft_start_consts.vh"
module soft_start_sequencer (
    clk_sys,
    nrst,
    ce,
    cmd_valid,
    cmd_write,
    cmd_code,
    cmd_wdata,
    cmd_rdata,
    restore,
    start_req,
    stop_req,
    vout_target,
    vout_sense,
    ref_out,
    ramping,
    power_on,
    uv_armed,
    invalid_data,
    invalid_cmd,
    status_none_above,
    status_vout,
    status_timeout,
    clear_faults,
    alert_n
);
    input wire clk_sys;
    input wire nrst;
    input wire ce;
    input wire cmd_valid;
    input wire cmd_write;
    input wire [7:0] cmd_code;
    input wire [15:0] cmd_wdata;
    output reg [15:0] cmd_rdata;
    input wire restore;
    input wire start_req;
    input wire stop_req;
    input wire [11:0] vout_target;
    input wire [11:0] vout_sense;
    output reg [11:0] ref_out;
    output reg ramping;
    output reg power_on;
    output reg uv_armed;
    output reg invalid_data;
    output reg invalid_cmd;
    output reg status_none_above;
    output reg status_vout;
    output reg status_timeout;
    input wire clear_faults;
    output reg alert_n;

    // ========================================
    // Helpers
    function [19:0] eighths_to_quarters;
        input [19:0] x;
        begin
            eighths_to_quarters = {1'b0, x[19:1]};
        end
    endfunction

    // ========================================
    // Input synchronisers
    reg [2:0] sync1_q;
    reg [2:0] sync2_q;
    reg [11:0] sense1_q;
    reg [11:0] sense2_q;
    wire start_s = sync2_q[0];
    wire stop_s = sync2_q[1];
    wire restore_s = sync2_q[2];
    reg start_prev_q;
    reg restore_prev_q;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            sense1_q <= 12'h000;
            sense2_q <= 12'h000;
            start_prev_q <= 1'b0;
            restore_prev_q <= 1'b0;
        end else if (ce) begin
            sync1_q <= {restore, stop_req, start_req};
            sync2_q <= sync1_q;
            sense1_q <= vout_sense;
            sense2_q <= sense1_q;
            start_prev_q <= start_s;
            restore_prev_q <= restore_s;
        end
    end
    wire start_rise = start_s & ~start_prev_q;
    wire restore_rise = restore_s & ~restore_prev_q;

    // ========================================
    // Command registers
    reg [15:0] delay_q;
    reg [15:0] rise_q;
    reg [15:0] limit_q;
    reg [7:0] resp_q;
    wire [19:0] wr_e8;
    wire wr_exact;
    wire wr_neg;
    wire [19:0] dly_e8;
    wire [19:0] rise_e8;
    wire [19:0] lim_e8;
    linear_to_eighths u_wr (
        .value(cmd_wdata),
        .eighths(wr_e8),
        .exact(wr_exact),
        .negative(wr_neg)
    );
    linear_to_eighths u_dly (
        .value(delay_q),
        .eighths(dly_e8),
        .exact(),
        .negative()
    );
    linear_to_eighths u_rise (
        .value(rise_q),
        .eighths(rise_e8),
        .exact(),
        .negative()
    );
    linear_to_eighths u_lim (
        .value(limit_q),
        .eighths(lim_e8),
        .exact(),
        .negative()
    );
    // Supported steps: delay 4 eighths, rise 2 eighths; limit writes are always refused
    wire wr_ok_base = wr_exact & ~wr_neg;
    wire dly_ok = wr_ok_base & (wr_e8[1:0] == 2'h0)
        & (wr_e8[19:2] <= `DELAY_MAX_Q); // [R5]
    wire rise_ok = wr_ok_base & ~wr_e8[0]
        & (wr_e8[19:1] <= `RISE_MAX_Q); // [R9]
    wire resp_ok = (cmd_wdata[`ACTION_HI:`ACTION_LO] != 2'h3)
        & (cmd_wdata[15:8] == 8'h00); // [R18]
    wire [15:0] dly_near = {5'h1f, 2'h0, dly_e8[19:2] > `DELAY_MAX_Q ?
        9'h0ff : dly_e8[10:2]};
    wire wr = cmd_valid & cmd_write;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            delay_q <= `DELAY_RESET; // [R2]
            rise_q <= `RISE_RESET;
            limit_q <= `TIMEOUT_RESET; // [R13]
            resp_q <= `RESPONSE_RESET; // [R17]
            invalid_data <= 1'b0;
            invalid_cmd <= 1'b0;
            cmd_rdata <= 16'h0000;
        end else if (ce) begin
            if (clear_faults) begin
                invalid_data <= 1'b0;
                invalid_cmd <= 1'b0;
            end
            // Nearest supported value, in 0.5 ms steps of 2^-1
            if (restore_rise) begin
                delay_q <= dly_near; // [R6]
            end
            if (wr) begin
                case (cmd_code)
                    `CMD_TURN_ON_DELAY: begin
                        if (dly_ok) begin
                            delay_q <= cmd_wdata; // [R1]
                        end else begin
                            invalid_data <= 1'b1; // [R4]
                        end
                    end
                    `CMD_RISE_TIME: begin
                        if (rise_ok) begin
                            rise_q <= cmd_wdata; // [R7]
                        end else begin
                            invalid_data <= 1'b1; // [R4]
                        end
                    end
                    `CMD_TIMEOUT_LIMIT: begin
                        invalid_cmd <= 1'b1; // [R15]
                    end
                    `CMD_TIMEOUT_RESPONSE: begin
                        if (resp_ok) begin
                            resp_q <= cmd_wdata[7:0]; // [R17]
                        end else begin
                            invalid_data <= 1'b1;
                        end
                    end
                    default: begin
                        invalid_cmd <= 1'b1;
                    end
                endcase
            end else if (cmd_valid) begin
                case (cmd_code)
                    `CMD_TURN_ON_DELAY: cmd_rdata <= delay_q;
                    `CMD_RISE_TIME: cmd_rdata <= rise_q;
                    `CMD_TIMEOUT_LIMIT: cmd_rdata <= limit_q;
                    `CMD_TIMEOUT_RESPONSE: cmd_rdata <= {8'h00, resp_q};
                    default: begin
                        cmd_rdata <= 16'h0000;
                        invalid_cmd <= 1'b1;
                    end
                endcase
            end
        end
    end

    // ========================================
    // Derived intervals in quarter milliseconds
    wire [19:0] dly_qtr = eighths_to_quarters(dly_e8); // [R21]
    wire [19:0] rise_raw = eighths_to_quarters(rise_e8);
    wire [19:0] rise_qtr = (rise_raw < `RISE_MIN_Q) ?
        `RISE_MIN_Q : rise_raw; // [R9]
    wire [19:0] lim_qtr = eighths_to_quarters(lim_e8);
    wire [1:0] action = resp_q[`ACTION_HI:`ACTION_LO];
    wire [2:0] restart_cnt = resp_q[`RESTART_HI:`RESTART_LO];
    wire [2:0] wait_code = resp_q[`WAIT_HI:`WAIT_LO];
    wire [19:0] shut_qtr = (wait_code == 3'h0) ? 20'h00004 :
        {15'h0000, wait_code, 2'h0}; // [R20]
    wire [19:0] restart_wait_period_qtr = (wait_code == 3'h0) ? rise_qtr :
        rise_qtr * {17'h00000, wait_code}; // [R20]

    // ========================================
    // Sequencer
    localparam [6:0] S_IDLE = 7'h01;
    localparam [6:0] S_INIT = 7'h02;
    localparam [6:0] S_DELAY = 7'h04;
    localparam [6:0] S_RAMP = 7'h08;
    localparam [6:0] S_ON = 7'h10;
    localparam [6:0] S_SHUT = 7'h20;
    localparam [6:0] S_RESTART_WAIT_PERIOD = 7'h40;
    reg [6:0] state_q;
    reg [14:0] init_q;
    reg [2:0] tries_q;
    reg watch_q;
    reg grace_q;
    reg [23:0] acc_q;
    reg t_start;
    reg [19:0] t_len;
    wire t_done;
    reg w_start;
    wire w_done;
    interval_timer u_seq (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .en(ce),
        .start(t_start),
        .stop(stop_s),
        .quarters(t_len),
        .done(t_done)
    );
    interval_timer u_watch (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .en(ce),
        .start(w_start),
        .stop(stop_s | ~watch_q),
        .quarters(lim_qtr),
        .done(w_done)
    );
    // Threshold 85% of target, compared in scaled units
    wire reached = ({8'h00, sense2_q} * 20'd100) >=
        ({8'h00, vout_target} * `TARGET_PERCENT); // [R11]
    // Ramp: step per cycle is target divided by rise count times QMS_CYCLES; the rise timer ends it, so duration
    // does not depend on target; integer division quantizes slope.
    wire [23:0] ramp_den = rise_qtr[7:0] * `QMS_CYCLES;
    wire [23:0] ramp_step = {vout_target, 12'h000} / ramp_den; // [R10]
    always @* begin
        t_start = 1'b0;
        t_len = 20'h00000;
        w_start = 1'b0;
        case (state_q)
            S_INIT: begin
                t_start = (init_q == `INIT_DELAY_CYCLES - 1);
                t_len = dly_qtr; // [R1]
            end
            S_DELAY: begin
                t_start = t_done;
                t_len = rise_qtr; // [R8]
                w_start = t_done & (lim_qtr != 20'h00000); // [R14]
            end
            S_ON: begin
                t_start = grace_q & (action == `ACT_DELAYED);
                t_len = shut_qtr;
            end
            S_SHUT: begin
                t_start = 1'b1;
                t_len = restart_wait_period_qtr;
            end
            default: begin
                t_start = 1'b0;
            end
        endcase
    end
    wire fault_now = w_done & ~reached; // [R11]
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_q <= S_IDLE;
            init_q <= 15'h0000;
            tries_q <= 3'h0;
            watch_q <= 1'b0;
            grace_q <= 1'b0;
            acc_q <= 24'h000000;
            ref_out <= 12'h000;
            ramping <= 1'b0;
            power_on <= 1'b0;
            uv_armed <= 1'b0;
            status_none_above <= 1'b0;
            status_vout <= 1'b0;
            status_timeout <= 1'b0;
            alert_n <= 1'b1;
        end else if (ce) begin
            grace_q <= 1'b0;
            if (clear_faults & ~fault_now) begin
                status_none_above <= 1'b0;
                status_vout <= 1'b0;
                status_timeout <= 1'b0;
            end
            // Set wins over clear
            if (fault_now) begin
                status_none_above <= 1'b1; // [R16]
                status_vout <= 1'b1; // [R16]
                status_timeout <= 1'b1; // [R16]
                grace_q <= 1'b1;
            end
            alert_n <= ~(fault_now | status_timeout | status_vout
                | status_none_above | invalid_data | invalid_cmd);
            if (watch_q & (reached | w_done)) begin
                watch_q <= 1'b0;
            end
            if (reached & watch_q) begin
                tries_q <= 3'h0;
            end
            if (stop_s) begin
                state_q <= S_IDLE;
                ramping <= 1'b0;
                power_on <= 1'b0;
                uv_armed <= 1'b0;
                ref_out <= 12'h000;
                watch_q <= 1'b0;
                tries_q <= 3'h0;
            end else begin
                case (state_q)
                    S_IDLE: begin
                        if (start_rise) begin
                            state_q <= S_INIT;
                            init_q <= 15'h0000;
                        end
                    end
                    S_INIT: begin
                        init_q <= init_q + 15'h0001; // [R3]
                        if (t_start) begin
                            state_q <= S_DELAY;
                        end
                    end
                    S_DELAY: begin
                        if (t_done) begin
                            state_q <= S_RAMP;
                            power_on <= 1'b1;
                            ramping <= 1'b1;
                            acc_q <= 24'h000000;
                            watch_q <= (lim_qtr != 20'h00000); // [R14]
                        end
                    end
                    S_RAMP: begin
                        acc_q <= acc_q + ramp_step;
                        ref_out <= (acc_q[23:12] >= vout_target) ?
                            vout_target : acc_q[23:12]; // [R7]
                        if (t_done) begin
                            ref_out <= vout_target;
                            ramping <= 1'b0;
                            uv_armed <= 1'b1; // [R12]
                            state_q <= S_ON;
                        end
                    end
                    default: begin
                        state_q <= S_IDLE;
                    end
                endcase
                // Fault may land during ramp or after it
                if (fault_now & (state_q == S_RAMP | state_q == S_ON)) begin
                    if (action == `ACT_IMMEDIATE) begin
                        state_q <= S_SHUT; // [R18]
                    end else begin
                        state_q <= S_ON;
                    end
                    if (state_q == S_RAMP & action != `ACT_IMMEDIATE) begin
                        ref_out <= vout_target;
                        ramping <= 1'b0;
                        uv_armed <= 1'b1;
                    end
                end
                if (state_q == S_ON & t_done & ~reached & action[0]) begin
                    state_q <= S_SHUT; // [R18]
                end
                if (state_q == S_SHUT) begin
                    power_on <= 1'b0;
                    ramping <= 1'b0;
                    uv_armed <= 1'b0;
                    ref_out <= 12'h000;
                    if (restart_cnt == 3'h0 |
                        (restart_cnt != `RESTART_FOREVER &
                        tries_q >= restart_cnt)) begin
                        state_q <= S_IDLE; // [R19]
                    end else begin
                        state_q <= S_RESTART_WAIT_PERIOD;
                        if (restart_cnt != `RESTART_FOREVER) begin
                            tries_q <= tries_q + 3'h1; // [R19]
                        end
                    end
                end
                if (state_q == S_RESTART_WAIT_PERIOD & t_done) begin
                    state_q <= S_INIT;
                    init_q <= 15'h0000;
                end
            end
        end
    end
endmodule

// file: shared/soft_start_consts.vh
/*
 Constants of the soft-start sequencer: command codes, field positions,
 reset values and timing counts. Assumes a 200 MHz system clock.
*/
`ifndef SOFT_START_CONSTS_VH
`define SOFT_START_CONSTS_VH
`define CMD_TURN_ON_DELAY 8'h60
`define CMD_RISE_TIME 8'h61
`define CMD_TIMEOUT_LIMIT 8'h62
`define CMD_TIMEOUT_RESPONSE 8'h63
`define EXP_HI 15
`define EXP_LO 11
`define MAN_HI 10
`define MAN_LO 0
`define ACTION_HI 7
`define ACTION_LO 6
`define RESTART_HI 5
`define RESTART_LO 3
`define WAIT_HI 2
`define WAIT_LO 0
`define DELAY_RESET 16'hf800
`define RISE_RESET 16'hf002
`define TIMEOUT_RESET 16'hf800
`define RESPONSE_RESET 8'h80
`define ACT_IGNORE 2'h0
`define ACT_DELAYED 2'h1
`define ACT_IMMEDIATE 2'h2
`define RESTART_FOREVER 3'h7
`define DELAY_MAX_Q 20'h000ff
`define RISE_MAX_Q 20'h0007f
`define RISE_MIN_Q 20'h00002
`define TIMEOUT_MAX_Q 20'h000fe
`define CLK_MHZ 200
`define QMS_US 250
`define QMS_CYCLES 16'hc350
`define INIT_DELAY_US 100
`define INIT_DELAY_CYCLES (`INIT_DELAY_US * `CLK_MHZ)
`define TARGET_PERCENT 85
`endif

// file: rtl/linear_to_eighths.v
/*
 Converts a linear-format word (signed exponent, signed mantissa) to a
 count of eighth-milliseconds. Assumes a combinational context.
*/
`timescale 1ns/100ps
`include "soft_start_consts.vh"
module linear_to_eighths (
    value,
    eighths,
    exact,
    negative
);
    input wire [15:0] value;
    output reg [19:0] eighths;
    output reg exact;
    output reg negative;
    reg signed [4:0] e;
    reg signed [10:0] m;
    reg [25:0] mag;
    reg signed [5:0] sh;
    always @* begin
        e = value[`EXP_HI:`EXP_LO];
        m = value[`MAN_HI:`MAN_LO];
        negative = m[10];
        mag = {15'h0000, m} << 3;
        sh = {e[4], e};
        exact = 1'b1;
        eighths = 20'h00000;
        if (negative) begin
            mag = 26'h0000000;
        end
        // Scale by 2^e; eighths keep 0.125 ms resolution
        if (sh >= 6'sd0) begin
            if (sh > 6'sd10) begin
                exact = (mag == 26'h0000000);
                mag = (mag == 26'h0000000) ? mag : 26'h3ffffff;
            end else begin
                mag = mag << sh[3:0];
            end
        end else if (sh >= -6'sd3) begin
            mag = mag >> (-sh);
        end else begin
            exact = 1'b0;
            mag = mag >> 3;
            mag = mag >> (-sh - 6'sd3);
        end
        eighths = (mag[25:20] != 6'h00) ? 20'hfffff : mag[19:0];
    end
endmodule

// file: rtl/interval_timer.v
/*
 Counts an interval in quarter-millisecond ticks of the system clock.
 Assumes start is a one-cycle pulse on clk_sys.
*/
`timescale 1ns/100ps
`include "soft_start_consts.vh"
module interval_timer (
    clk_sys,
    nrst,
    en,
    start,
    stop,
    quarters,
    done
);
    input wire clk_sys;
    input wire nrst;
    input wire en;
    input wire start;
    input wire stop;
    input wire [19:0] quarters;
    output reg done;
    reg [15:0] sub_q;
    reg [19:0] left_q;
    reg run_q;
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sub_q <= 16'h0000;
            left_q <= 20'h00000;
            run_q <= 1'b0;
            done <= 1'b0;
        end else if (en) begin
            done <= 1'b0;
            if (stop) begin
                run_q <= 1'b0;
            end else if (start) begin
                run_q <= (quarters != 20'h00000);
                done <= (quarters == 20'h00000);
                left_q <= quarters;
                sub_q <= 16'h0000;
            end else if (run_q) begin
                if (sub_q == `QMS_CYCLES - 16'h0001) begin
                    sub_q <= 16'h0000;
                    left_q <= left_q - 20'h00001;
                    if (left_q == 20'h00001) begin
                        run_q <= 1'b0;
                        done <= 1'b1;
                    end
                end else begin
                    sub_q <= sub_q + 16'h0001;
                end
            end
        end
    end
endmodule

// file: bench/soft_start_sequencer_props.sv
/* Port assertions of the soft-start sequencer.
   Assumes it is bound into soft_start_sequencer. */
`timescale 1ns/100ps
`include "soft_start_consts.vh"
// ==========================================
// Checker
module soft_start_sequencer_props (
    input wire clk_sys,
    input wire nrst,
    input wire ce,
    input wire cmd_valid,
    input wire cmd_write,
    input wire [7:0] cmd_code,
    input wire [15:0] cmd_wdata,
    input wire [15:0] cmd_rdata,
    input wire stop_req,
    input wire power_on,
    input wire ramping,
    input wire uv_armed,
    input wire invalid_data,
    input wire invalid_cmd,
    input wire status_none_above,
    input wire status_vout,
    input wire status_timeout,
    input wire clear_faults,
    input wire alert_n
);
    wire rd_go = ce && cmd_valid && !cmd_write;
    wire wr_go = ce && cmd_valid && cmd_write;
    wire sticky = invalid_data | invalid_cmd | status_none_above |
        status_vout | status_timeout;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_limit_refused: assert property (wr_go && cmd_code == 8'h62
        |=> invalid_cmd) else $error("limit write not refused");
    a_limit_fixed: assert property (rd_go && cmd_code == 8'h62
        |=> cmd_rdata == 16'hf800) else $error("limit changed");
    a_delay_range: assert property (wr_go && cmd_code == 8'h60
        && cmd_wdata == 16'hf900 |=> invalid_data)
        else $error("long delay accepted");
    a_action_bad: assert property (wr_go && cmd_code == 8'h63
        && cmd_wdata[7:6] == 2'h3 |=> invalid_data)
        else $error("bad action accepted");
    a_unknown_read: assert property (rd_go && cmd_code > 8'h63
        |=> cmd_rdata == 16'h0000) else $error("unknown code read");
    a_rdata_holds: assert property (!rd_go |=> $stable(cmd_rdata))
        else $error("read data moved");
    a_sticky_alert: assert property (sticky |-> ##[0:1] !alert_n)
        else $error("alert missing");
    a_quiet_alert: assert property (!sticky && !$past(sticky)
        |-> alert_n) else $error("alert without fault");
    a_stop_off: assert property (stop_req [*4] |-> !power_on && !ramping)
        else $error("stop ignored");
    a_ramp_power: assert property (ramping |-> power_on)
        else $error("ramp without power");
    a_uv_rise: assert property ($rose(uv_armed) |-> $past(ramping))
        else $error("undervoltage armed early");
    a_sticky_hold: assert property (invalid_data && !clear_faults
        |=> invalid_data) else $error("flag lost");
endmodule
bind soft_start_sequencer soft_start_sequencer_props i_props (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .cmd_rdata(cmd_rdata), .stop_req(stop_req), .power_on(power_on),
    .ramping(ramping), .uv_armed(uv_armed), .invalid_data(invalid_data),
    .invalid_cmd(invalid_cmd), .status_none_above(status_none_above),
    .status_vout(status_vout), .status_timeout(status_timeout),
    .clear_faults(clear_faults), .alert_n(alert_n)
);

// file: bench/host_model.sv
/* Host side of the command port, one command per xfer call.
   Assumes calls only after reset release. */
`timescale 1ns/100ps
// ==========================================
// Host
module host_model (
    input wire clk_sys,
    input wire [15:0] cmd_rdata,
    output logic cmd_valid,
    output logic cmd_write,
    output logic [7:0] cmd_code,
    output logic [15:0] cmd_wdata,
    output logic rd_done
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
        rd_done = 1'b0;
    end
    task automatic xfer(input logic wr, input logic [7:0] code,
        input logic [15:0] data);
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_write <= wr;
        cmd_code <= code;
        cmd_wdata <= (code == 8'h63) ? {8'h00, data[7:0]} : data;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        // Released bus must not keep the old word
        cmd_wdata <= ~data;
        rd_done <= !wr;
        @(posedge clk_sys);
        rd_done <= 1'b0;
    endtask
endmodule

// file: bench/soft_start_sequencer_tb.sv
/* Self-checking bench of the soft-start sequencer.
   Assumes the host model drives the command port. */
`timescale 1ns/100ps
`include "soft_start_consts.vh"
// ==========================================
// Bench
module soft_start_sequencer_tb;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic restore = 1'b0;
    logic start_req = 1'b0;
    logic stop_req = 1'b0;
    logic clear_faults = 1'b0;
    logic [11:0] vout_target = 12'ha00;
    wire cmd_valid, cmd_write, rd_done, ramping, power_on, uv_armed;
    wire invalid_data, invalid_cmd, status_none_above, status_vout;
    wire status_timeout, alert_n;
    wire [7:0] cmd_code;
    wire [15:0] cmd_wdata, cmd_rdata;
    wire [11:0] ref_out;
    int fail_count = 0;
    int comparisons = 0;
    int n;
    logic [15:0] v, r;
    logic [15:0] exp_q[$];
    // Sense tied low: output never reaches target here
    soft_start_sequencer i_dut (.clk_sys(clk_sys), .nrst(nrst),
        .ce(1'b1), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
        .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_rdata(cmd_rdata),
        .restore(restore), .start_req(start_req), .stop_req(stop_req),
        .vout_target(vout_target), .vout_sense(12'h000),
        .ref_out(ref_out), .ramping(ramping), .power_on(power_on),
        .uv_armed(uv_armed), .invalid_data(invalid_data),
        .invalid_cmd(invalid_cmd), .status_none_above(status_none_above),
        .status_vout(status_vout), .status_timeout(status_timeout),
        .clear_faults(clear_faults), .alert_n(alert_n));
    host_model i_host (.clk_sys(clk_sys), .cmd_rdata(cmd_rdata),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rd_done(rd_done));
    initial begin
        forever #2.5 clk_sys = ~clk_sys;
    end
    task check(input string what, input logic [15:0] seen,
        input logic [15:0] want);
        comparisons++;
        if (seen !== want) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task test_done;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task wr(input logic [7:0] c, input logic [15:0] d);
        i_host.xfer(1'b1, c, d);
    endtask
    task rd(input logic [7:0] c, input logic [15:0] e);
        exp_q.push_back(e);
        i_host.xfer(1'b0, c, 16'h0000);
    endtask
    task bad(input logic [7:0] c, input logic [15:0] d,
        input logic [15:0] keep);
        wr(c, d);
        @(negedge clk_sys);
        check("invalid_flag", invalid_data | invalid_cmd, 16'h0001);
        check("alert_n", alert_n, 16'h0000);
        rd(c, keep);
        @(posedge clk_sys) clear_faults <= 1'b1;
        @(posedge clk_sys) clear_faults <= 1'b0;
    endtask
    // Oldest note is matched against each read answer
    always @(posedge clk_sys) begin
        if (rd_done === 1'b1) begin
            check("cmd_rdata", cmd_rdata, exp_q.pop_front());
        end
    end
    initial begin
        void'($urandom(96));
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        rd(`CMD_TURN_ON_DELAY, `DELAY_RESET);
        rd(`CMD_RISE_TIME, `RISE_RESET);
        rd(`CMD_TIMEOUT_LIMIT, `TIMEOUT_RESET);
        rd(`CMD_TIMEOUT_RESPONSE, {8'h00, `RESPONSE_RESET});
        rd(8'h64, 16'h0000);
        repeat (4) begin
            v = {5'h1f, 3'h0, 8'($urandom)};
            wr(`CMD_TURN_ON_DELAY, v);
            rd(`CMD_TURN_ON_DELAY, v);
            r = {5'h1e, 4'h0, 7'($urandom % 126 + 2)};
            wr(`CMD_RISE_TIME, r);
            rd(`CMD_RISE_TIME, r);
        end
        for (int a = 0; a < 3; a++) begin
            v = {8'h00, 2'(a), 6'($urandom)};
            wr(`CMD_TIMEOUT_RESPONSE, v);
            rd(`CMD_TIMEOUT_RESPONSE, v);
        end
        wr(`CMD_TURN_ON_DELAY, 16'h0005);
        @(posedge clk_sys) restore <= 1'b1;
        repeat (4) @(posedge clk_sys);
        restore <= 1'b0;
        rd(`CMD_TURN_ON_DELAY, 16'hf80a);
        bad(`CMD_TURN_ON_DELAY, 16'hf900, 16'hf80a);
        bad(`CMD_RISE_TIME, 16'hf080, r);
        bad(`CMD_TIMEOUT_RESPONSE, 16'h00c0, v);
        bad(`CMD_TIMEOUT_LIMIT, 16'h0000, `TIMEOUT_RESET);
        wr(`CMD_TURN_ON_DELAY, 16'hf800);
        @(posedge clk_sys) start_req <= 1'b1;
        n = 0;
        // Zero delay still costs the init wait
        while (power_on !== 1'b1 && n < 20300) begin
            @(posedge clk_sys);
            n++;
        end
        check("start_wait", 16'(n >= 19990 && n < 20300), 16'h0001);
        if (n >= 20300) test_done;
        repeat (5000) @(posedge clk_sys);
        @(negedge clk_sys);
        check("ramping", ramping, 16'h0001);
        v = 16'(ref_out > 12'h000 && ref_out < vout_target);
        check("ref_out_rising", v, 16'h0001);
        check("uv_armed", uv_armed, 16'h0000);
        @(posedge clk_sys) stop_req <= 1'b1;
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys);
        check("power_on", power_on, 16'h0000);
        check("status_timeout", status_timeout, 16'h0000);
        test_done;
    end
endmodule
